// file: common/gate_ctrl_pkg.sv
// Constants and types shared by the enable and gate control logic
package gate_ctrl_pkg;

    localparam int unsigned CLK_FREQ_MHZ    = 250;
    localparam int unsigned CLK_PERIOD_NS   = 4;

    // Gate outputs must fall within this time of enable going low
    localparam int unsigned GATE_OFF_NS     = 100;
    localparam int unsigned GATE_OFF_CYC    = (GATE_OFF_NS / CLK_PERIOD_NS) < 1 ? 1
                                              : GATE_OFF_NS / CLK_PERIOD_NS;
    // Least low time of enable before a low-power state is entered
    localparam int unsigned LOWPWR_US       = 1000;
    localparam int unsigned LOWPWR_CYC      = LOWPWR_US * CLK_FREQ_MHZ;
    // Least low time of enable that arms a wake from Sleep
    localparam int unsigned WAKE_US         = 250;
    localparam int unsigned WAKE_CYC        = WAKE_US * CLK_FREQ_MHZ;

    localparam int unsigned CNT_W           = 20;
    localparam int unsigned DT_W            = 8;

    // Register map
    localparam logic [3:0]  ADDR_CONFIG_REG_ZERO       = 4'h0;
    localparam logic [3:0]  ADDR_DEADTIME_CONFIG_REG       = 4'h2;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;
    localparam logic [3:0]  ADDR_FAULT      = 4'h5;

    // config_reg_zero fields
    localparam int unsigned CONFIG_REG_ZERO_SLEEP_BIT  = 0;
    localparam int unsigned CONFIG_REG_ZERO_PULLUP_BIT = 1;
    localparam int unsigned CONFIG_REG_ZERO_VARIANT_BIT = 2;
    localparam logic [7:0]  CONFIG_REG_ZERO_RESET      = 8'h00;
    // deadtime_config_reg fields
    localparam int unsigned DEADTIME_CONFIG_REG_DTEN_BIT   = 7;
    localparam logic [7:0]  DEADTIME_CONFIG_REG_RESET      = 8'h00;

    typedef enum logic [1:0] {
        PM_ACTIVE  = 2'b00,
        PM_PENDING = 2'b01,
        PM_STANDBY = 2'b10,
        PM_SLEEP   = 2'b11
    } pmode_e;

endpackage : gate_ctrl_pkg

// file: rtl/phase_gate.sv
// One half-bridge: interlock and optional dead-time insertion
module phase_gate #(
    parameter int unsigned DW = 8
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          high_in,
    input  wire logic          low_in,
    input  wire logic          allow,
    input  wire logic          dt_en,
    input  wire logic [DW-1:0] dt_cycles,
    output logic               high_out,
    output logic               low_out
);
    logic          high_q, high_d;
    logic          low_q,  low_d;
    logic [DW-1:0] cnt_q,  cnt_d;
    logic          want_h, want_l;

    always_comb begin
        // Both inputs high means neither side conducts
        want_h = allow && high_in && !low_in;
        want_l = allow && low_in && !high_in;
        high_d = 1'b0;
        low_d  = 1'b0;
        cnt_d  = cnt_q;
        if (high_q || low_q) begin
            // Gap is counted only once both sides are off
            cnt_d  = '0;
            high_d = want_h && (high_q || !dt_en);
            low_d  = want_l && (low_q || !dt_en);
        end else if (!dt_en || cnt_q >= dt_cycles) begin
            // Long idle already covers the gap, so no extra wait
            high_d = want_h;
            low_d  = want_l;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            high_q <= 1'b0;
            low_q  <= 1'b0;
            cnt_q  <= '0;
        end else begin
            high_q <= high_d;
            low_q  <= low_d;
            cnt_q  <= cnt_d;
        end
    end

    assign high_out = high_q;
    assign low_out  = low_q;

    property p_no_shoot;
        @(posedge clock) disable iff (rst) !(high_q && low_q);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both sides on");

    property p_dead_gap;
        @(posedge clock) disable iff (rst)
            (dt_en && dt_cycles != 0 && $fell(low_q)) |-> !high_q;
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("no dead time");

endmodule : phase_gate

// file: rtl/enable_mode_gate_control.sv
// Enable sequencing, low-power modes, fault latch and gate outputs
//
// Operation
// - Enable high turns on every function including gate outputs.
// - Enable low puts device in Standby or Sleep, never normal operation.
// - Standby disables amplifiers and 12V regulator; buck, supervisor, monitors stay.
// - On the translator variant Standby also disables the 5V regulator.
// - Enable low forces all six gate outputs low within 100 ns.
// - Low-power state entered only after enable low continuously for 1 ms.
// - Enable rising edge clears latched faults if the condition is gone.
// - Sleep bit set selects Sleep as the low-power state, else Standby.
// - Sleep wake needs enable low 250 us, then wakes on rising edge.
// - Each phase low-side drive input controls its low-side gate output.
// - Each phase high-side drive input controls its high-side gate output.
// - Gate outputs are active high.
// - Dead time comes from host waveforms or from the dead-time register.
// - Undriven enable reads as low, defaulting to the disabled state.
// - Pull-up enable bit is sampled only while enable is low.
// - Fault open-drain output pulled low while a fault is active.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
module enable_mode_gate_control
    import gate_ctrl_pkg::*;
#(
    parameter int unsigned LOWPWR_CYCLES = LOWPWR_CYC,
    parameter int unsigned WAKE_CYCLES   = WAKE_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        chip_enable_in,
    input  wire logic        phase_a_high_drive_in,
    input  wire logic        phase_a_low_drive_in,
    input  wire logic        phase_b_high_drive_in,
    input  wire logic        phase_b_low_drive_in,
    input  wire logic        phase_c_high_drive_in,
    input  wire logic        phase_c_low_drive_in,
    input  wire logic        driver_fault_in,
    input  wire logic        supervisor_fault_in,
    input  wire logic        overcurrent_in,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [7:0]       reg_rdata,
    output logic             gate_a_high_out,
    output logic             gate_a_low_out,
    output logic             gate_b_high_out,
    output logic             gate_b_low_out,
    output logic             gate_c_high_out,
    output logic             gate_c_low_out,
    output logic             overcurrent_fault_out,
    output logic             overcurrent_fault_oe_n,
    output logic             supervisor_flag_out,
    output logic             supervisor_flag_oe_n,
    output logic             amp_enable,
    output logic             ldo12_enable,
    output logic             ldo5_enable,
    output logic             buck_enable,
    output logic             monitor_enable,
    output logic             input_pullup_enable,
    output logic [1:0]       power_mode
);
    import gate_ctrl_pkg::*;

    // Registers
    logic [7:0] config_reg_zero_q, config_reg_zero_d;
    logic [7:0] deadtime_config_reg_q, deadtime_config_reg_d;
    logic [7:0] rdata_q, rdata_d;

    // Mode sequencing
    pmode_e             mode_q, mode_d;
    logic [CNT_W-1:0]   low_cnt_q, low_cnt_d;
    logic               ce_q;
    logic               wake_armed_q, wake_armed_d;
    logic               fault_q, fault_d;
    logic               pullup_q, pullup_d;

    // Output registers
    logic amp_q, amp_d;
    logic ldo12_q, ldo12_d;
    logic ldo5_q, ldo5_d;
    logic ocf_oe_n_q, ocf_oe_n_d;
    logic sup_oe_n_q, sup_oe_n_d;

    logic ce_rise;
    logic gate_allow;
    logic [5:0] gates;

    // Port is taken as the pin after its pull-down, so undriven means low
    assign ce_rise = chip_enable_in && !ce_q;

    always_comb begin
        config_reg_zero_d = config_reg_zero_q;
        deadtime_config_reg_d = deadtime_config_reg_q;
        if (reg_write && reg_addr == ADDR_CONFIG_REG_ZERO) begin
            config_reg_zero_d = reg_wdata;
        end
        if (reg_write && reg_addr == ADDR_DEADTIME_CONFIG_REG) begin
            deadtime_config_reg_d = reg_wdata;
        end
        rdata_d = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                ADDR_CONFIG_REG_ZERO:   rdata_d = config_reg_zero_q;
                ADDR_DEADTIME_CONFIG_REG:   rdata_d = deadtime_config_reg_q;
                ADDR_STATUS: rdata_d = {4'h0, wake_armed_q, ce_q, mode_q};
                ADDR_FAULT:  rdata_d = {5'h00, overcurrent_in, driver_fault_in, fault_q};
                default:     rdata_d = 8'h00;
            endcase
        end
    end

    always_comb begin
        mode_d       = mode_q;
        low_cnt_d    = low_cnt_q;
        wake_armed_d = wake_armed_q;
        fault_d      = fault_q;
        pullup_d     = pullup_q;

        // Latch wins over clear when the fault is still present
        if (driver_fault_in) begin
            fault_d = 1'b1;
        end else if (ce_rise) begin
            fault_d = 1'b0;
        end

        if (!chip_enable_in) begin
            pullup_d = config_reg_zero_q[CONFIG_REG_ZERO_PULLUP_BIT];
            if (low_cnt_q != CNT_W'(LOWPWR_CYCLES)) begin
                low_cnt_d = low_cnt_q + 1'b1;
            end
            if (low_cnt_q >= CNT_W'(WAKE_CYCLES - 1)) begin
                wake_armed_d = 1'b1;
            end
        end else begin
            low_cnt_d = '0;
        end

        case (mode_q)
            PM_ACTIVE: begin
                if (!chip_enable_in) begin
                    mode_d = PM_PENDING;
                end
            end
            PM_PENDING: begin
                if (chip_enable_in) begin
                    mode_d = PM_ACTIVE;
                end else if (low_cnt_q >= CNT_W'(LOWPWR_CYCLES - 1)) begin
                    mode_d = config_reg_zero_q[CONFIG_REG_ZERO_SLEEP_BIT] ? PM_SLEEP : PM_STANDBY;
                end
            end
            PM_STANDBY: begin
                if (chip_enable_in) begin
                    mode_d = PM_ACTIVE;
                end
            end
            PM_SLEEP: begin
                if (ce_rise && wake_armed_q) begin
                    mode_d = PM_ACTIVE;
                end
            end
            default: mode_d = PM_STANDBY;
        endcase
        if (mode_d == PM_ACTIVE) begin
            wake_armed_d = 1'b0;
        end
    end

    always_comb begin
        amp_d   = (mode_d == PM_ACTIVE);
        ldo12_d = (mode_d == PM_ACTIVE || mode_d == PM_PENDING);
        ldo5_d  = !(config_reg_zero_q[CONFIG_REG_ZERO_VARIANT_BIT] && mode_d[1]);
        ocf_oe_n_d = !(fault_d || overcurrent_in);
        sup_oe_n_d = !supervisor_fault_in;
    end

    // Enable is acted on the same edge it is seen, well inside the off time
    assign gate_allow = chip_enable_in && mode_q != PM_SLEEP && mode_q != PM_STANDBY
                        && !fault_q && !driver_fault_in;

    phase_gate #(.DW(DT_W - 1)) u_phase_a (
        .clock     (clock),
        .rst       (rst),
        .high_in   (phase_a_high_drive_in),
        .low_in    (phase_a_low_drive_in),
        .allow     (gate_allow),
        .dt_en     (deadtime_config_reg_q[DEADTIME_CONFIG_REG_DTEN_BIT]),
        .dt_cycles (deadtime_config_reg_q[DT_W-2:0]),
        .high_out  (gates[0]),
        .low_out   (gates[1])
    );
    phase_gate #(.DW(DT_W - 1)) u_phase_b (
        .clock     (clock),
        .rst       (rst),
        .high_in   (phase_b_high_drive_in),
        .low_in    (phase_b_low_drive_in),
        .allow     (gate_allow),
        .dt_en     (deadtime_config_reg_q[DEADTIME_CONFIG_REG_DTEN_BIT]),
        .dt_cycles (deadtime_config_reg_q[DT_W-2:0]),
        .high_out  (gates[2]),
        .low_out   (gates[3])
    );
    phase_gate #(.DW(DT_W - 1)) u_phase_c (
        .clock     (clock),
        .rst       (rst),
        .high_in   (phase_c_high_drive_in),
        .low_in    (phase_c_low_drive_in),
        .allow     (gate_allow),
        .dt_en     (deadtime_config_reg_q[DEADTIME_CONFIG_REG_DTEN_BIT]),
        .dt_cycles (deadtime_config_reg_q[DT_W-2:0]),
        .high_out  (gates[4]),
        .low_out   (gates[5])
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            config_reg_zero_q       <= CONFIG_REG_ZERO_RESET;
            deadtime_config_reg_q       <= DEADTIME_CONFIG_REG_RESET;
            rdata_q      <= 8'h00;
            mode_q       <= PM_STANDBY;
            low_cnt_q    <= '0;
            ce_q         <= 1'b0;
            wake_armed_q <= 1'b0;
            fault_q      <= 1'b0;
            pullup_q     <= 1'b0;
            amp_q        <= 1'b0;
            ldo12_q      <= 1'b0;
            ldo5_q       <= 1'b1;
            ocf_oe_n_q   <= 1'b1;
            sup_oe_n_q   <= 1'b1;
        end else begin
            config_reg_zero_q       <= config_reg_zero_d;
            deadtime_config_reg_q       <= deadtime_config_reg_d;
            rdata_q      <= rdata_d;
            mode_q       <= mode_d;
            low_cnt_q    <= low_cnt_d;
            ce_q         <= chip_enable_in;
            wake_armed_q <= wake_armed_d;
            fault_q      <= fault_d;
            pullup_q     <= pullup_d;
            amp_q        <= amp_d;
            ldo12_q      <= ldo12_d;
            ldo5_q       <= ldo5_d;
            ocf_oe_n_q   <= ocf_oe_n_d;
            sup_oe_n_q   <= sup_oe_n_d;
        end
    end

    // Gate outputs come straight from the phase flops; active high
    assign gate_a_high_out = gates[0];
    assign gate_a_low_out  = gates[1];
    assign gate_b_high_out = gates[2];
    assign gate_b_low_out  = gates[3];
    assign gate_c_high_out = gates[4];
    assign gate_c_low_out  = gates[5];

    // Open-drain pins only ever pull low
    assign overcurrent_fault_out  = 1'b0;
    assign overcurrent_fault_oe_n = ocf_oe_n_q;
    assign supervisor_flag_out    = 1'b0;
    assign supervisor_flag_oe_n   = sup_oe_n_q;

    assign reg_rdata           = rdata_q;
    assign amp_enable          = amp_q;
    assign ldo12_enable        = ldo12_q;
    assign ldo5_enable         = ldo5_q;
    assign buck_enable         = 1'b1;
    assign monitor_enable      = 1'b1;
    assign input_pullup_enable = pullup_q;
    assign power_mode          = mode_q;

    property p_gate_off;
        @(posedge clock) disable iff (rst)
            !chip_enable_in |=> (gates == 6'h00);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gates on after disable");

    property p_no_early_lowpwr;
        @(posedge clock) disable iff (rst)
            (mode_q == PM_PENDING && chip_enable_in) |=> mode_q == PM_ACTIVE;
    endproperty
    a_no_early_lowpwr: assert property (p_no_early_lowpwr) else $error("short low entered lowpwr");

    property p_lowpwr_entry;
        @(posedge clock) disable iff (rst)
            $changed(mode_q) && mode_q[1] |-> low_cnt_q >= CNT_W'(LOWPWR_CYCLES);
    endproperty
    a_lowpwr_entry: assert property (p_lowpwr_entry) else $error("lowpwr before time");

    property p_sleep_sel;
        @(posedge clock) disable iff (rst)
            (mode_q == PM_PENDING && mode_d[1]) |=> mode_q == ($past(config_reg_zero_q[CONFIG_REG_ZERO_SLEEP_BIT])
                ? PM_SLEEP : PM_STANDBY);
    endproperty
    a_sleep_sel: assert property (p_sleep_sel) else $error("wrong lowpwr state");

    property p_fault_clear;
        @(posedge clock) disable iff (rst)
            (ce_rise && !driver_fault_in) |=> !fault_q;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

    property p_fault_gates;
        @(posedge clock) disable iff (rst)
            fault_q |=> gates == 6'h00;
    endproperty
    a_fault_gates: assert property (p_fault_gates) else $error("gates on in fault");

    property p_fault_pin;
        @(posedge clock) disable iff (rst)
            driver_fault_in |=> !overcurrent_fault_oe_n;
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin not low");

    property p_pullup_hold;
        @(posedge clock) disable iff (rst)
            chip_enable_in |=> $stable(pullup_q);
    endproperty
    a_pullup_hold: assert property (p_pullup_hold) else $error("pullup changed enabled");

    property p_sleep_wake;
        @(posedge clock) disable iff (rst)
            (mode_q == PM_SLEEP && ce_rise && !wake_armed_q) |=> mode_q == PM_SLEEP;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("woke too soon");

endmodule : enable_mode_gate_control

// file: test/host_model.sv
// Host model driving the enable pin and the six phase drive inputs
module host_model (
    input  wire logic clock,
    output logic      chip_enable_in,
    output logic      phase_a_high_drive_in,
    output logic      phase_a_low_drive_in,
    output logic      phase_b_high_drive_in,
    output logic      phase_b_low_drive_in,
    output logic      phase_c_high_drive_in,
    output logic      phase_c_low_drive_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chip_enable_in = 1'b0;
        {phase_c_high_drive_in, phase_c_low_drive_in, phase_b_high_drive_in,
         phase_b_low_drive_in, phase_a_high_drive_in, phase_a_low_drive_in} = 6'h00;
    end

    task automatic drive(input logic [5:0] pat);
        @(posedge clock);
        {phase_c_high_drive_in, phase_c_low_drive_in, phase_b_high_drive_in,
         phase_b_low_drive_in, phase_a_high_drive_in, phase_a_low_drive_in} <= pat;
    endtask : drive

    task automatic set_ce(input logic v);
        @(posedge clock);
        chip_enable_in <= v;
    endtask : set_ce

    // Kept short of the entry count so a fault clears without entering Standby or Sleep
    task automatic pulse_low(input int n);
        set_ce(1'b0);
        repeat (n) @(posedge clock);
        chip_enable_in <= 1'b1;
    endtask : pulse_low

    // Host-made dead time: all drives off for a gap before the new pattern
    task automatic commutate(input logic [5:0] pat, input int gap);
        drive(6'h00);
        repeat (gap) @(posedge clock);
        {phase_c_high_drive_in, phase_c_low_drive_in, phase_b_high_drive_in,
         phase_b_low_drive_in, phase_a_high_drive_in, phase_a_low_drive_in} <= pat;
    endtask : commutate
endmodule : host_model

// file: test/tb_enable_mode_gate_control.sv
// Self-checking bench for enable sequencing, faults and gate outputs
module tb_enable_mode_gate_control;
    import gate_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Short counts keep the run brief; expectations derive from them
    localparam int LOW_N  = 200;
    localparam int WAKE_N = 50;
    localparam int DT     = 5;

    logic clock, rst, chip_enable_in, driver_fault_in, supervisor_fault_in, overcurrent_in;
    logic phase_a_high_drive_in, phase_a_low_drive_in, phase_b_high_drive_in;
    logic phase_b_low_drive_in, phase_c_high_drive_in, phase_c_low_drive_in;
    logic [3:0] reg_addr, a;
    logic [7:0] reg_wdata, reg_rdata, d, v;
    logic [1:0] f;
    logic reg_write, reg_read;
    logic gate_a_high_out, gate_a_low_out, gate_b_high_out, gate_b_low_out;
    logic gate_c_high_out, gate_c_low_out, overcurrent_fault_out, overcurrent_fault_oe_n;
    logic supervisor_flag_out, supervisor_flag_oe_n, amp_enable, ldo12_enable, ldo5_enable;
    logic buck_enable, monitor_enable, input_pullup_enable;
    logic [1:0] power_mode;
    logic [5:0] gates, pat;
    int errors, n_compared, n;
    integer seed = 32'hF952;

    assign gates = {gate_c_high_out, gate_c_low_out, gate_b_high_out, gate_b_low_out,
                    gate_a_high_out, gate_a_low_out};

    host_model host_model_i (.clock, .chip_enable_in, .phase_a_high_drive_in,
        .phase_a_low_drive_in, .phase_b_high_drive_in, .phase_b_low_drive_in,
        .phase_c_high_drive_in, .phase_c_low_drive_in);

    enable_mode_gate_control #(.LOWPWR_CYCLES(LOW_N), .WAKE_CYCLES(WAKE_N))
    enable_mode_gate_control_i (.clock, .rst, .chip_enable_in, .phase_a_high_drive_in,
        .phase_a_low_drive_in, .phase_b_high_drive_in, .phase_b_low_drive_in,
        .phase_c_high_drive_in, .phase_c_low_drive_in, .driver_fault_in,
        .supervisor_fault_in, .overcurrent_in, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .gate_a_high_out, .gate_a_low_out, .gate_b_high_out,
        .gate_b_low_out, .gate_c_high_out, .gate_c_low_out, .overcurrent_fault_out,
        .overcurrent_fault_oe_n, .supervisor_flag_out, .supervisor_flag_oe_n,
        .amp_enable, .ldo12_enable, .ldo5_enable, .buck_enable, .monitor_enable,
        .input_pullup_enable, .power_mode);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Reference: a phase follows its drives only when exactly one is high
    function automatic logic [5:0] gate_model(input logic [5:0] p, input logic on);
        logic [5:0] g;
        g = 6'h00;
        for (int i = 0; i < 3; i++)
            if (on && (p[2*i] ^ p[2*i+1])) g[2*i +: 2] = p[2*i +: 2];
        return g;
    endfunction : gate_model

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : cyc

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_rd

    task automatic low_hold;
        host_model_i.set_ce(1'b0);
        cyc(LOW_N + 10);
    endtask : low_hold

    task automatic summarize;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    initial begin
        repeat (10000) @(posedge clock);
        errors++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        {driver_fault_in, supervisor_fault_in, overcurrent_in, reg_write, reg_read} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        cyc(2);
        chk("mode", PM_STANDBY, power_mode);
        chk("amp ldo12 ldo5", 3'b001, {amp_enable, ldo12_enable, ldo5_enable});
        chk("buck monitor", 2'b11, {buck_enable, monitor_enable});
        chk("open-drain data", 2'b00, {overcurrent_fault_out, supervisor_flag_out});
        chk("gates", 6'h00, gates);
        reg_rd(ADDR_CONFIG_REG_ZERO);
        chk("config_reg_zero", CONFIG_REG_ZERO_RESET, d);
        reg_rd(ADDR_DEADTIME_CONFIG_REG);
        chk("deadtime_config_reg", DEADTIME_CONFIG_REG_RESET, d);
        reg_rd(4'hF);
        chk("unmapped", 8'h00, d);
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            a = 4'h8 | 4'($random(seed));
            reg_wr(ADDR_DEADTIME_CONFIG_REG, v);
            reg_rd(ADDR_DEADTIME_CONFIG_REG);
            chk("deadtime_config_reg", v, d);
            reg_rd(a);
            chk("unmapped", 8'h00, d);
        end
        reg_wr(ADDR_DEADTIME_CONFIG_REG, DEADTIME_CONFIG_REG_RESET);
        reg_wr(ADDR_STATUS, 8'hFF);
        reg_rd(ADDR_STATUS);
        chk("status mode", PM_STANDBY, d[1:0]);
        cyc(1);
        chk("rdata idle", 8'h00, reg_rdata);
        host_model_i.set_ce(1'b1);
        cyc(3);
        chk("mode", PM_ACTIVE, power_mode);
        chk("amp ldo12 ldo5", 3'b111, {amp_enable, ldo12_enable, ldo5_enable});
        for (int i = 0; i < 24; i++) begin
            pat = (i == 0) ? 6'h3F : 6'($random(seed));
            host_model_i.drive(pat);
            cyc(2);
            chk("gates", gate_model(pat, 1'b1), gates);
        end
        host_model_i.drive(6'h2A);
        cyc(2);
        host_model_i.set_ce(1'b0);
        cyc(1);
        chk("gates off", 6'h00, gates);
        chk("mode", PM_PENDING, power_mode);
        chk("amp ldo12 ldo5", 3'b011, {amp_enable, ldo12_enable, ldo5_enable});
        cyc(LOW_N - 10);
        host_model_i.set_ce(1'b1);
        cyc(3);
        chk("mode", PM_ACTIVE, power_mode);
        chk("gates", 6'h2A, gates);
        @(posedge clock);
        driver_fault_in <= 1'b1;
        cyc(3);
        chk("gates fault", 6'h00, gates);
        chk("fault pin oe_n", 1'b0, overcurrent_fault_oe_n);
        host_model_i.pulse_low(5);
        cyc(3);
        reg_rd(ADDR_FAULT);
        chk("latched", 1'b1, d[0]);
        @(posedge clock);
        driver_fault_in <= 1'b0;
        cyc(3);
        chk("gates latched", 6'h00, gates);
        host_model_i.pulse_low(5);
        cyc(3);
        reg_rd(ADDR_FAULT);
        chk("latched", 1'b0, d[0]);
        chk("mode", PM_ACTIVE, power_mode);
        chk("gates", 6'h2A, gates);
        chk("fault pin oe_n", 1'b1, overcurrent_fault_oe_n);
        @(posedge clock);
        {overcurrent_in, supervisor_fault_in} <= 2'b11;
        cyc(2);
        chk("fault pin oe_n", 1'b0, overcurrent_fault_oe_n);
        chk("supervisor oe_n", 1'b0, supervisor_flag_oe_n);
        @(posedge clock);
        {overcurrent_in, supervisor_fault_in} <= 2'b00;
        cyc(2);
        chk("both oe_n", 2'b11, {overcurrent_fault_oe_n, supervisor_flag_oe_n});
        for (int i = 0; i < 8; i++) begin
            f = 2'($random(seed));
            @(posedge clock);
            {overcurrent_in, supervisor_fault_in} <= f;
            cyc(2);
            chk("oc sup oe_n", 2'(~f), {overcurrent_fault_oe_n, supervisor_flag_oe_n});
        end
        @(posedge clock);
        {overcurrent_in, supervisor_fault_in} <= 2'b00;
        reg_wr(ADDR_CONFIG_REG_ZERO, 8'h02);
        cyc(3);
        chk("pullup", 1'b0, input_pullup_enable);
        low_hold();
        chk("mode", PM_STANDBY, power_mode);
        chk("pullup", 1'b1, input_pullup_enable);
        chk("amp ldo12 ldo5", 3'b001, {amp_enable, ldo12_enable, ldo5_enable});
        reg_wr(ADDR_CONFIG_REG_ZERO, 8'h06);
        cyc(2);
        chk("amp ldo12 ldo5", 3'b000, {amp_enable, ldo12_enable, ldo5_enable});
        host_model_i.set_ce(1'b1);
        cyc(3);
        chk("mode", PM_ACTIVE, power_mode);
        reg_wr(ADDR_DEADTIME_CONFIG_REG, 8'h80 | DT);
        host_model_i.drive(6'h01);
        cyc(DT + 4);
        chk("a low", 6'h01, gates);
        host_model_i.drive(6'h02);
        n = 0;
        while (gate_a_high_out !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk("dead time in range", 1'b1, n >= DT + 1 && n <= DT + 2);
        reg_wr(ADDR_DEADTIME_CONFIG_REG, 8'h00);
        host_model_i.commutate(6'h01, 3);
        cyc(2);
        chk("host dead time", 6'h01, gates);
        reg_wr(ADDR_CONFIG_REG_ZERO, 8'h01);
        low_hold();
        chk("mode", PM_SLEEP, power_mode);
        chk("gates", 6'h00, gates);
        reg_rd(ADDR_STATUS);
        chk("status mode", PM_SLEEP, d[1:0]);
        host_model_i.set_ce(1'b1);
        cyc(3);
        chk("mode", PM_ACTIVE, power_mode);
        summarize();
    end
endmodule : tb_enable_mode_gate_control
